// *** rtl/rts_pkg.sv ***
package rts_pkg;

    ////////////////////////////////////////////////////////////////////////
    // widths
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int TORQUE_W = 16;
    localparam int STATUS_W = 4;

    ////////////////////////////////////////////////////////////////////////
    // register offsets (byte addresses, one word each)
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DROOP_LIMIT = 8'h04;
    localparam logic [7:0] OFS_STROKE_UPPER = 8'h08;
    localparam logic [7:0] OFS_STROKE_LOWER = 8'h0C;
    localparam logic [7:0] OFS_SPEED_LIMIT = 8'h10;
    localparam logic [7:0] OFS_FIXED_PULSES = 8'h14;
    localparam logic [7:0] OFS_FIXED_TRAVEL = 8'h18;
    localparam logic [7:0] OFS_TABLE_REV = 8'h1C;
    localparam logic [7:0] OFS_INT_STATUS = 8'h20;
    localparam logic [7:0] OFS_INT_CLEAR = 8'h24;
    localparam logic [7:0] OFS_INT_ENABLE = 8'h28;
    localparam logic [7:0] OFS_TORQUE_LIMIT = 8'h2C;
    localparam logic [7:0] OFS_GEAR_RATIO = 8'h30;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int CTRL_VIRTUAL = 0;
    localparam int CTRL_TORQUE_SRC = 1;
    localparam int ST_DROOP = 0;
    localparam int ST_STROKE = 1;
    localparam int ST_SPEED = 2;
    localparam int ST_TABLE_REV = 3;
    localparam int GEAR_FRAC = 16;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam logic [31:0] DROOP_RESET = 32'h0063_FF9C;
    localparam logic [31:0] STROKE_RESET = 32'h0000_0000;
    localparam logic [31:0] SPEED_RESET = 32'h0000_0000;
    localparam logic [31:0] FIXED_PULSES_RESET = 32'h0001_0000;
    localparam logic [31:0] FIXED_TRAVEL_RESET = 32'h0225_5100;
    localparam logic [31:0] GEAR_RESET = 32'h0001_0000;
    localparam logic [15:0] TORQUE_DEFAULT = 16'h012C;
    // one full turn in 0.00001 degree units
    localparam logic [31:0] FULL_TURN = 32'h0225_5100;

    ////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic signed [31:0] speed;
        logic signed [31:0] travel;
    } rts_cmd_s;

    typedef enum logic [1:0] {
        REV_IDLE = 2'b00,
        REV_START = 2'b01,
        REV_WAIT = 2'b10
    } rts_rev_state_e;

endpackage : rts_pkg

// *** rtl/rts_divider.sv ***
module rts_divider #(
    parameter int NUM_W = 64,
    parameter int DEN_W = 32,
    parameter int QUO_W = 32
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_b_in,
    // request
    input wire logic start_in,
    input wire logic [NUM_W-1:0] num_in,
    input wire logic [DEN_W-1:0] den_in,
    // answer
    output logic busy_out,
    output logic done_out,
    output logic [QUO_W-1:0] quo_out
);

    localparam int CNT_W = $clog2(NUM_W + 1);

    // the saturation slice needs spare numerator bits above the quotient
    if (NUM_W < 2 || QUO_W >= NUM_W || DEN_W < 1) begin : g_bad_widths
        $error("rts_divider: unsupported widths");
    end

    logic [DEN_W:0] rem;
    logic [NUM_W-1:0] num_sh;
    logic [NUM_W-1:0] quo;
    logic [CNT_W-1:0] count;
    logic [DEN_W:0] trial;

    assign trial = {rem[DEN_W-1:0], num_sh[NUM_W-1]};

    ////////////////////////////////////////////////////////////////////////
    // restoring division, one quotient bit per clock
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            rem <= '0;
            num_sh <= '0;
            quo <= '0;
            count <= '0;
            busy_out <= 1'b0;
            done_out <= 1'b0;
            quo_out <= '0;
        end else begin
            done_out <= 1'b0;
            if (start_in && !busy_out) begin
                rem <= '0;
                num_sh <= num_in;
                quo <= '0;
                count <= CNT_W'(NUM_W);
                busy_out <= 1'b1;
            end else if (busy_out) begin
                num_sh <= {num_sh[NUM_W-2:0], 1'b0};
                if (trial >= {1'b0, den_in}) begin
                    rem <= trial - {1'b0, den_in};
                    quo <= {quo[NUM_W-2:0], 1'b1};
                end else begin
                    rem <= trial;
                    quo <= {quo[NUM_W-2:0], 1'b0};
                end
                count <= count - 1'b1;
                if (count == CNT_W'(1)) begin
                    busy_out <= 1'b0;
                    done_out <= 1'b1;
                end
            end
            // saturate once the last bit has landed
            if (busy_out && count == CNT_W'(0)) begin
                quo_out <= '0;
            end
            if (!busy_out && count == CNT_W'(0) && done_out) begin
                if (|quo[NUM_W-1:QUO_W]) begin
                    quo_out <= '1;
                end else begin
                    quo_out <= quo[QUO_W-1:0];
                end
            end
        end
    end

endmodule : rts_divider

// *** rtl/rts_axis_supervisor.sv ***
// Function
// RULE_01: droop above limit sets axis error flag
// RULE_02: axis keeps moving after any error
// RULE_03: droop limit 1 to 1073741824, default 6553500
// RULE_04: stroke limits 0 to 359.99999 degrees
// RULE_05: equal stroke limits disable stroke check
// RULE_06: leaving stroke range flags error, no stop
// RULE_07: overspeed flags error, speed not clamped
// RULE_08: speed limit range set by software
// RULE_09: converted speed limit 1 to 2147483647 pulses/s
// RULE_10: pulses per table rev derived, not set
// RULE_11: torque limit always applied, default 300 percent
// RULE_12: torque word value 1 to 1000 percent
// RULE_13: assigned torque word drives torque limit
// RULE_14: torque source chosen from allowed areas
// RULE_15: dedicated data register block reserved
// RULE_16: output axis number 1 to 32 or 8
// RULE_17: command is drive value times gear ratio
// RULE_18: checks per motion cycle, flag held until cleared
//
// The plain strobed port and the address map were chosen for this implementation.
module rts_axis_supervisor (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_b_in,
    // register port
    input wire logic [rts_pkg::ADDR_W-1:0] addr_in,
    input wire logic [rts_pkg::DATA_W-1:0] wr_data_in,
    input wire logic wr_strobe_in,
    input wire logic rd_strobe_in,
    output logic [rts_pkg::DATA_W-1:0] rd_data_out,
    // motion cycle and axis feedback
    input wire logic cycle_tick_in,
    input wire logic signed [31:0] deviation_in,
    input wire logic [31:0] position_in,
    input wire logic signed [31:0] axis_speed_in,
    // drive module values
    input wire logic signed [31:0] drive_speed_in,
    input wire logic signed [31:0] drive_travel_in,
    // torque source word
    input wire logic [rts_pkg::TORQUE_W-1:0] torque_word_in,
    // amplifier side
    output rts_pkg::rts_cmd_s cmd_out,
    output logic [rts_pkg::TORQUE_W-1:0] torque_limit_out,
    // status
    output logic axis_error_flag_out,
    output logic irq_out
);

    ////////////////////////////////////////////////////////////////////////
    // functions

    function automatic logic [31:0] abs_val(input logic signed [31:0] v);
        abs_val = v[31] ? 32'(-v) : 32'(v);
    endfunction : abs_val

    function automatic logic signed [31:0] gear_scale(
        input logic signed [31:0] v,
        input logic [31:0] ratio
    );
        logic signed [64:0] prod;
        prod = 65'(v) * $signed({33'h0_0000_0000, ratio});
        gear_scale = prod[rts_pkg::GEAR_FRAC+31:rts_pkg::GEAR_FRAC];
    endfunction : gear_scale

    ////////////////////////////////////////////////////////////////////////
    // register file

    logic [31:0] ctrl;
    logic [31:0] droop_limit;
    logic [31:0] stroke_upper;
    logic [31:0] stroke_lower;
    logic [31:0] axis_speed_limit;
    logic [31:0] fixed_pulses_per_rev;
    logic [31:0] fixed_travel_per_rev;
    logic [31:0] gear_ratio;
    logic [rts_pkg::STATUS_W-1:0] int_enable;
    logic [31:0] pulses_per_table_rev;

    function automatic logic hit(input logic [7:0] ofs);
        hit = wr_strobe_in && (addr_in == ofs);
    endfunction : hit

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            ctrl <= rts_pkg::CTRL_RESET;
            droop_limit <= rts_pkg::DROOP_RESET;
            stroke_upper <= rts_pkg::STROKE_RESET;
            stroke_lower <= rts_pkg::STROKE_RESET;
            axis_speed_limit <= rts_pkg::SPEED_RESET;
            gear_ratio <= rts_pkg::GEAR_RESET;
            int_enable <= '0;
        end else begin
            if (hit(rts_pkg::OFS_CTRL)) begin
                ctrl <= wr_data_in & 32'h0000_0003;
            end
            if (hit(rts_pkg::OFS_DROOP_LIMIT)) begin
                droop_limit <= wr_data_in;
            end
            if (hit(rts_pkg::OFS_STROKE_UPPER)) begin
                stroke_upper <= wr_data_in;
            end
            if (hit(rts_pkg::OFS_STROKE_LOWER)) begin
                stroke_lower <= wr_data_in;
            end
            if (hit(rts_pkg::OFS_SPEED_LIMIT)) begin
                axis_speed_limit <= wr_data_in;
            end
            if (hit(rts_pkg::OFS_GEAR_RATIO)) begin
                gear_ratio <= wr_data_in;
            end
            if (hit(rts_pkg::OFS_INT_ENABLE)) begin
                int_enable <= wr_data_in[rts_pkg::STATUS_W-1:0];
            end
        end
    end

    // fixed parameters: any write starts a new table revolution figure once the current one ends
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            fixed_pulses_per_rev <= rts_pkg::FIXED_PULSES_RESET;
            fixed_travel_per_rev <= rts_pkg::FIXED_TRAVEL_RESET;
        end else begin
            if (hit(rts_pkg::OFS_FIXED_PULSES)) begin
                fixed_pulses_per_rev <= wr_data_in;
            end
            if (hit(rts_pkg::OFS_FIXED_TRAVEL)) begin
                fixed_travel_per_rev <= wr_data_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pulses per table revolution = pulses per rev * 360 / travel per rev

    rts_pkg::rts_rev_state_e rev_state;
    rts_pkg::rts_rev_state_e next_rev_state;
    logic rev_pending;
    logic div_start;
    logic div_busy;
    logic div_done;
    logic [31:0] div_quo;
    logic [63:0] rev_num;

    assign rev_num = 64'(fixed_pulses_per_rev) * 64'(rts_pkg::FULL_TURN);
    assign div_start = (rev_state == rts_pkg::REV_START);

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            rev_pending <= 1'b1;
        end else if (hit(rts_pkg::OFS_FIXED_PULSES) ||
                     hit(rts_pkg::OFS_FIXED_TRAVEL)) begin
            rev_pending <= 1'b1;
        end else if (div_start) begin
            rev_pending <= 1'b0;
        end
    end

    always_comb begin
        next_rev_state = rev_state;
        case (rev_state)
            rts_pkg::REV_IDLE: begin
                if (rev_pending) begin
                    next_rev_state = rts_pkg::REV_START;
                end
            end
            rts_pkg::REV_START: begin
                next_rev_state = rts_pkg::REV_WAIT;
            end
            rts_pkg::REV_WAIT: begin
                if (div_done) begin
                    next_rev_state = rts_pkg::REV_IDLE;
                end
            end
            default: begin
                next_rev_state = rts_pkg::REV_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            rev_state <= rts_pkg::REV_IDLE;
        end else begin
            rev_state <= next_rev_state;
        end
    end

    rts_divider #(
        .NUM_W(64),
        .DEN_W(32),
        .QUO_W(32)
    ) u_divider (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .start_in(div_start),
        .num_in(rev_num),
        .den_in(fixed_travel_per_rev),
        .busy_out(div_busy),
        .done_out(div_done),
        .quo_out(div_quo)
    );

    logic rev_ready;

    // quotient register lands one edge after the done pulse
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            rev_ready <= 1'b0;
        end else begin
            rev_ready <= div_done;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            pulses_per_table_rev <= '0;
        end else if (rev_ready) begin
            pulses_per_table_rev <= div_quo; // see RULE_10
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // limit checks, sampled on the motion cycle tick

    logic check_en;
    logic droop_hit;
    logic speed_hit;
    logic stroke_on;
    logic in_stroke;
    logic stroke_hit;

    assign check_en = cycle_tick_in && ctrl[rts_pkg::CTRL_VIRTUAL];
    assign droop_hit = abs_val(deviation_in) > droop_limit; // see RULE_01
    assign speed_hit = abs_val(axis_speed_in) > axis_speed_limit; // see RULE_07
    assign stroke_on = (stroke_upper != stroke_lower); // see RULE_05
    // a lower limit above the upper one means the range wraps through 0
    assign in_stroke = (stroke_lower < stroke_upper) ?
        (position_in >= stroke_lower && position_in <= stroke_upper) :
        (position_in >= stroke_lower || position_in <= stroke_upper);
    assign stroke_hit = stroke_on && !in_stroke; // see RULE_06

    ////////////////////////////////////////////////////////////////////////
    // sticky status, set wins over clear

    logic [rts_pkg::STATUS_W-1:0] int_status;
    logic [rts_pkg::STATUS_W-1:0] next_int_status;
    logic [rts_pkg::STATUS_W-1:0] next_int_enable;
    logic [rts_pkg::STATUS_W-1:0] set_mask;
    logic [rts_pkg::STATUS_W-1:0] clr_mask;

    always_comb begin
        set_mask = '0;
        set_mask[rts_pkg::ST_DROOP] = check_en && droop_hit;
        set_mask[rts_pkg::ST_STROKE] = check_en && stroke_hit;
        set_mask[rts_pkg::ST_SPEED] = check_en && speed_hit;
        set_mask[rts_pkg::ST_TABLE_REV] = rev_ready;
        clr_mask = hit(rts_pkg::OFS_INT_CLEAR) ?
            wr_data_in[rts_pkg::STATUS_W-1:0] : '0;
        next_int_status = (int_status & ~clr_mask) | set_mask; // see RULE_18
        next_int_enable = hit(rts_pkg::OFS_INT_ENABLE) ?
            wr_data_in[rts_pkg::STATUS_W-1:0] : int_enable;
    end

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            int_status <= '0;
            axis_error_flag_out <= 1'b0;
            irq_out <= 1'b0;
        end else begin
            int_status <= next_int_status;
            axis_error_flag_out <= |next_int_status[rts_pkg::ST_SPEED:0];
            irq_out <= |(next_int_status & next_int_enable);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // amplifier command and torque limit

    // errors never gate the command path: the axis runs on
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            cmd_out <= '0;
        end else begin
            cmd_out.speed <= gear_scale(drive_speed_in, gear_ratio); // see RULE_17
            cmd_out.travel <= gear_scale(drive_travel_in, gear_ratio); // see RULE_02
        end
    end

    // word arrives already fetched from its area (see RULE_14)
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            torque_limit_out <= rts_pkg::TORQUE_DEFAULT;
        end else if (ctrl[rts_pkg::CTRL_TORQUE_SRC]) begin
            torque_limit_out <= torque_word_in; // see RULE_13
        end else begin
            torque_limit_out <= rts_pkg::TORQUE_DEFAULT; // see RULE_11
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port, data valid for one cycle after the strobe

    logic [31:0] next_rd_data;

    always_comb begin
        next_rd_data = '0;
        if (rd_strobe_in) begin
            case (addr_in)
                rts_pkg::OFS_CTRL: next_rd_data = ctrl;
                rts_pkg::OFS_DROOP_LIMIT: next_rd_data = droop_limit;
                rts_pkg::OFS_STROKE_UPPER: next_rd_data = stroke_upper;
                rts_pkg::OFS_STROKE_LOWER: next_rd_data = stroke_lower;
                rts_pkg::OFS_SPEED_LIMIT: next_rd_data = axis_speed_limit;
                rts_pkg::OFS_FIXED_PULSES: next_rd_data = fixed_pulses_per_rev;
                rts_pkg::OFS_FIXED_TRAVEL: next_rd_data = fixed_travel_per_rev;
                rts_pkg::OFS_TABLE_REV: next_rd_data = pulses_per_table_rev;
                rts_pkg::OFS_INT_STATUS: next_rd_data = 32'(int_status);
                rts_pkg::OFS_INT_ENABLE: next_rd_data = 32'(int_enable);
                rts_pkg::OFS_TORQUE_LIMIT: next_rd_data = 32'(torque_limit_out);
                rts_pkg::OFS_GEAR_RATIO: next_rd_data = gear_ratio;
                default: next_rd_data = '0;
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            rd_data_out <= '0;
        end else begin
            rd_data_out <= next_rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    logic clr_err;
    assign clr_err = hit(rts_pkg::OFS_INT_CLEAR) &&
        (|wr_data_in[rts_pkg::ST_SPEED:0]);

    a_droop_flag: assert property ( // see RULE_01
        @(posedge clock_in) disable iff (!rst_b_in)
        check_en && abs_val(deviation_in) > droop_limit
        |=> axis_error_flag_out && int_status[rts_pkg::ST_DROOP])
        else $error("droop overrun did not raise the error flag");

    a_speed_flag: assert property ( // see RULE_07
        @(posedge clock_in) disable iff (!rst_b_in)
        check_en && abs_val(axis_speed_in) > axis_speed_limit
        |=> int_status[rts_pkg::ST_SPEED])
        else $error("overspeed did not raise the error flag");

    a_stroke_off: assert property ( // see RULE_05
        @(posedge clock_in) disable iff (!rst_b_in)
        stroke_upper == stroke_lower && !int_status[rts_pkg::ST_STROKE]
        |=> !int_status[rts_pkg::ST_STROKE])
        else $error("stroke flag set with stroke check disabled");

    a_stroke_flag: assert property ( // see RULE_06
        @(posedge clock_in) disable iff (!rst_b_in)
        check_en && stroke_on && !in_stroke
        |=> int_status[rts_pkg::ST_STROKE] && axis_error_flag_out)
        else $error("stroke exit did not raise the error flag");

    a_flag_sticky: assert property ( // see RULE_18
        @(posedge clock_in) disable iff (!rst_b_in)
        axis_error_flag_out && !clr_err |=> axis_error_flag_out)
        else $error("error flag dropped without a clear");

    a_cmd_gear: assert property ( // see RULE_17
        @(posedge clock_in) disable iff (!rst_b_in)
        1'b1 |=> cmd_out.speed ==
            gear_scale($past(drive_speed_in), $past(gear_ratio)) &&
            cmd_out.travel ==
            gear_scale($past(drive_travel_in), $past(gear_ratio)))
        else $error("command is not drive value times gear ratio");

    a_torque_default: assert property ( // see RULE_11
        @(posedge clock_in) disable iff (!rst_b_in)
        !ctrl[rts_pkg::CTRL_TORQUE_SRC]
        |=> torque_limit_out == rts_pkg::TORQUE_DEFAULT)
        else $error("default torque limit not applied");

    a_torque_word: assert property ( // see RULE_13
        @(posedge clock_in) disable iff (!rst_b_in)
        ctrl[rts_pkg::CTRL_TORQUE_SRC]
        |=> torque_limit_out == $past(torque_word_in))
        else $error("torque word not applied");

    a_rev_bound: assert property ( // see RULE_10
        @(posedge clock_in) disable iff (!rst_b_in)
        div_start |-> ##[1:80] rev_ready ##1
            pulses_per_table_rev == $past(div_quo))
        else $error("table revolution figure not produced in time");

    a_read_once: assert property (
        @(posedge clock_in) disable iff (!rst_b_in)
        !rd_strobe_in |=> rd_data_out == 32'h0000_0000)
        else $error("read data outside the answer cycle");

    c_droop: cover property (
        @(posedge clock_in) disable iff (!rst_b_in)
        check_en && droop_hit ##1 axis_error_flag_out);

    c_stroke_wrap: cover property (
        @(posedge clock_in) disable iff (!rst_b_in)
        check_en && stroke_lower > stroke_upper && stroke_hit);

    c_set_and_clear: cover property (
        @(posedge clock_in) disable iff (!rst_b_in)
        clr_err && check_en && droop_hit);

    c_rev_done: cover property (
        @(posedge clock_in) disable iff (!rst_b_in)
        rev_ready && div_busy == 1'b0);

endmodule : rts_axis_supervisor

// *** dv/rts_servo_model.sv ***
module rts_servo_model (
    // clock
    input wire logic clock_in,
    // command from the supervisor
    input wire rts_pkg::rts_cmd_s cmd_in,
    // lag and angle chosen by the bench
    input wire logic signed [31:0] lag_in,
    input wire logic [31:0] angle_in,
    // feedback
    output logic signed [31:0] deviation_out,
    output logic [31:0] position_out,
    output logic signed [31:0] speed_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        deviation_out = 32'sh0000_0000;
        position_out = 32'h0000_0000;
        speed_out = 32'sh0000_0000;
    end
    // motor follows the command one cycle late, never clamped
    always @(posedge clock_in) begin
        speed_out <= cmd_in.speed;
        deviation_out <= lag_in;
        position_out <= angle_in;
    end
endmodule : rts_servo_model

// *** dv/rts_axis_supervisor_test.sv ***
module rts_axis_supervisor_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_in, rst_b_in, wr_strobe_in, rd_strobe_in, cycle_tick_in;
    logic [7:0] addr_in;
    logic [31:0] wr_data_in, rd_data_out, position_in, angle, v;
    logic signed [31:0] deviation_in, axis_speed_in, lag;
    logic signed [31:0] drive_speed_in, drive_travel_in;
    logic [15:0] torque_word_in, torque_limit_out;
    rts_pkg::rts_cmd_s cmd_out;
    logic axis_error_flag_out, irq_out;
    int mismatches = 0;
    int check_count = 0;
    rts_axis_supervisor rts_axis_supervisor_inst (.clock_in, .rst_b_in,
        .addr_in, .wr_data_in, .wr_strobe_in, .rd_strobe_in, .rd_data_out,
        .cycle_tick_in, .deviation_in, .position_in, .axis_speed_in,
        .drive_speed_in, .drive_travel_in, .torque_word_in, .cmd_out,
        .torque_limit_out, .axis_error_flag_out, .irq_out);
    // one amplifier, wired as output axis 1
    rts_servo_model rts_servo_model_inst (.clock_in, .cmd_in(cmd_out),
        .lag_in(lag), .angle_in(angle), .deviation_out(deviation_in),
        .position_out(position_in), .speed_out(axis_speed_in));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_strobe_in <= 1'b1;
        @(posedge clock_in);
        wr_strobe_in <= 1'b0;
    endtask : wr
    task automatic rd_chk(input string what, input logic [7:0] a,
        input logic [31:0] e);
        @(posedge clock_in);
        addr_in <= a;
        rd_strobe_in <= 1'b1;
        @(posedge clock_in);
        rd_strobe_in <= 1'b0;
        #1 v = rd_data_out;
        chk(what, e, v);
    endtask : rd_chk
    // one motion tick, returns once its results have landed
    task automatic tick;
        @(posedge clock_in);
        cycle_tick_in <= 1'b1;
        @(posedge clock_in);
        cycle_tick_in <= 1'b0;
        #1;
    endtask : tick
    task automatic settle;
        @(posedge clock_in);
        #1;
    endtask : settle
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd_chk("ctrl", rts_pkg::OFS_CTRL, rts_pkg::CTRL_RESET);
        rd_chk("droop", rts_pkg::OFS_DROOP_LIMIT, rts_pkg::DROOP_RESET);
        chk("torque", 32'(rts_pkg::TORQUE_DEFAULT), 32'(torque_limit_out));
        $display("test reset done");
    endtask : t_reset
    task automatic t_droop;
        wr(rts_pkg::OFS_DROOP_LIMIT, 32'h0000_0064);
        lag <= 32'sh0000_0064;
        tick();
        chk("flag at limit", 32'h0, 32'(axis_error_flag_out));
        lag <= -32'sh0000_0065;
        wr(rts_pkg::OFS_CTRL, 32'h0000_0000);
        tick();
        chk("flag off mode", 32'h0, 32'(axis_error_flag_out));
        wr(rts_pkg::OFS_CTRL, 32'h0000_0001);
        tick();
        chk("flag over", 32'h1, 32'(axis_error_flag_out));
        chk("irq masked", 32'h0, 32'(irq_out));
        wr(rts_pkg::OFS_INT_ENABLE, 32'h0000_0001);
        settle();
        chk("irq on", 32'h1, 32'(irq_out));
        lag <= 32'sh0000_0000;
        tick();
        chk("flag held", 32'h1, 32'(axis_error_flag_out));
        wr(rts_pkg::OFS_INT_CLEAR, 32'h0000_0001);
        settle();
        chk("flag cleared", 32'h0, 32'(axis_error_flag_out));
        chk("irq off", 32'h0, 32'(irq_out));
        $display("test droop done");
    endtask : t_droop
    task automatic t_stroke;
        angle <= 32'h0007_A120;
        tick();
        chk("stroke off", 32'h0, 32'(axis_error_flag_out));
        wr(rts_pkg::OFS_STROKE_LOWER, 32'h0001_86A0);
        wr(rts_pkg::OFS_STROKE_UPPER, 32'h0003_0D40);
        tick();
        chk("stroke out", 32'h1, 32'(axis_error_flag_out));
        angle <= 32'h0002_49F0;
        wr(rts_pkg::OFS_INT_CLEAR, 32'h0000_0002);
        tick();
        chk("stroke in", 32'h0, 32'(axis_error_flag_out));
        $display("test stroke done");
    endtask : t_stroke
    task automatic t_speed;
        wr(rts_pkg::OFS_SPEED_LIMIT, 32'h0000_0032);
        wr(rts_pkg::OFS_GEAR_RATIO, 32'h0002_0000);
        drive_speed_in <= 32'sh0000_003C;
        drive_travel_in <= 32'sh0000_0007;
        repeat (3) settle();
        tick();
        chk("overspeed", 32'h1, 32'(axis_error_flag_out));
        chk("speed cmd", 32'h0000_0078, cmd_out.speed);
        chk("travel cmd", 32'h0000_000E, cmd_out.travel);
        $display("test speed done");
    endtask : t_speed
    task automatic t_torque;
        torque_word_in <= 16'h01F4;
        wr(rts_pkg::OFS_CTRL, 32'h0000_0003);
        settle();
        chk("torque word", 32'h0000_01F4, 32'(torque_limit_out));
        wr(rts_pkg::OFS_CTRL, 32'h0000_0001);
        settle();
        chk("torque dflt", 32'h0000_012C, 32'(torque_limit_out));
        $display("test torque done");
    endtask : t_torque
    task automatic t_rev;
        logic [31:0] e;
        e = 32'(64'h2_0000 * 64'(rts_pkg::FULL_TURN) /
            64'(rts_pkg::FIXED_TRAVEL_RESET));
        // let the start-up table figure finish before restarting it
        repeat (30) @(posedge clock_in);
        wr(rts_pkg::OFS_INT_CLEAR, 32'h0000_000F);
        wr(rts_pkg::OFS_FIXED_PULSES, 32'h0002_0000);
        repeat (80) @(posedge clock_in);
        rd_chk("rev ready", rts_pkg::OFS_INT_STATUS, 32'h0000_0008);
        chk("ready bit", 32'h8, v & 32'h8);
        wr(rts_pkg::OFS_TABLE_REV, 32'h0000_0000);
        rd_chk("table rev", rts_pkg::OFS_TABLE_REV, e);
        rd_chk("unmapped", 8'h40, 32'h0000_0000);
        $display("test rev done");
    endtask : t_rev
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end
    initial begin
        {rst_b_in, wr_strobe_in, rd_strobe_in, cycle_tick_in} = 4'h0;
        {addr_in, wr_data_in, lag, angle} = '0;
        {drive_speed_in, drive_travel_in, torque_word_in} = '0;
        repeat (12) @(posedge clock_in);
        rst_b_in <= 1'b1;
        t_reset();
        t_droop();
        t_stroke();
        t_speed();
        t_torque();
        t_rev();
        complete_run();
    end
    initial begin
        #200000;
        mismatches++;
        complete_run();
    end
endmodule : rts_axis_supervisor_test
